// ==== hdl/crrs_pkg.sv ====
// Shared constants for the four-instruction executor
package crrs_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned PC_W = 13;
  localparam int unsigned FA_W = 7;
  localparam int unsigned SP_W = 3;
  localparam int unsigned STACK_DEPTH = 8;
  localparam logic [3:0] CYCLE_CLKS = 4'h4;
  localparam logic [3:0] CYCLES_RETURN = 4'h2;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  localparam logic [5:0] OP_RRF_HI = 6'h0c;
  localparam logic [4:0] OP_SUB_HI = 5'h1e;
  localparam int unsigned DEST_BIT = 7;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [4:0] ADR_ACCUM = 5'h00;
  localparam logic [4:0] ADR_STATUS = 5'h04;
  localparam logic [4:0] ADR_PC = 5'h08;
  localparam logic [4:0] ADR_STACK = 5'h0c;
  localparam logic [4:0] ADR_WDOG = 5'h10;
  localparam logic [4:0] ADR_CTRL = 5'h14;
  localparam logic [4:0] ADR_FADDR = 5'h18;
  localparam logic [4:0] ADR_FDATA = 5'h1c;

  // ****************************************************************
  // Status and control field positions and register reset values
  // ****************************************************************
  localparam int unsigned ST_C_POS = 0;
  localparam int unsigned ST_DC_POS = 1;
  localparam int unsigned ST_Z_POS = 2;
  localparam int unsigned ST_PD_POS = 3;
  localparam int unsigned ST_TO_POS = 4;
  localparam int unsigned CTRL_WAKE_POS = 0;
  localparam logic RST_PD = 1'b1;
  localparam logic RST_TO = 1'b1;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic [7:0] RST_ACCUM = 8'h00;

  // ****************************************************************
  // State encodings
  // ****************************************************************
  typedef enum logic [1:0] {CORE_IDLE, CORE_BUSY, CORE_SLEEP} crrs_core_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_RD, BUS_ACK} crrs_bus_t;

endpackage

// ==== hdl/crrs_fmem.sv ====
// Dual-port file register memory with registered read data
`timescale 1ns/100ps
module crrs_fmem #(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 8
) (
  input wire logic clk,
  input wire logic [AW-1:0] a_addr,
  input wire logic a_we,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  input wire logic [AW-1:0] b_addr,
  input wire logic b_we,
  input wire logic [DW-1:0] b_wdata,
  output logic [DW-1:0] b_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Port a written last so the core wins a same-address clash
  always_ff @(posedge clk) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end

endmodule // crrs_fmem

// ==== hdl/crrs_core.sv ====
// Executor for return, rotate right, sleep and literal subtract
// Contract
// - A return pops the stack into the program counter, keeps all flags and takes two cycles.
// - Rotate right moves the file register right through carry, old carry into bit 7.
// - The destination bit sends the rotate result to the accumulator at 0 or the file at 1.
// - Sleep clears the power-down flag.
// - Sleep sets the timeout flag.
// - Sleep clears the watchdog counter and its prescaler.
// - After the one-cycle sleep the core halts its oscillator.
// - Literal subtract writes literal minus accumulator back to the accumulator.
// - Literal subtract sets carry when no borrow and clears it on borrow.
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module crrs_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [13:0] instr_word,
  output logic instr_ready,
  output logic [12:0] prog_addr,
  output logic osc_run,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    crrs_pkg::crrs_core_t st;
    logic [3:0] hold;
    logic ready;
    logic osc;
    logic [12:0] pc;
    logic [2:0] sp;
    logic [7:0][12:0] stack;
    logic [7:0] w;
    logic c;
    logic dc;
    logic z;
    logic pd;
    logic to;
    logic [7:0] wdt;
    logic [7:0] pre;
    logic [6:0] fa;
    logic fd;
    logic rrf_pend;
    logic slp;
    crrs_pkg::crrs_bus_t bst;
    logic wait_r;
    logic [31:0] rdata;
    logic [6:0] faddr;
  } crrs_state_t;

  crrs_state_t state_reg;
  crrs_state_t state_next;
  logic take;
  logic rrf_wb;
  logic [12:0] stack_top_entry;
  logic [7:0] lit_k;
  logic [7:0] a_rdata;
  logic [7:0] b_rdata;
  logic [7:0] rot_res;
  logic b_we;
  logic [8:0] diff9;
  logic [4:0] diff5;

  // Decode helpers
  assign take = instr_valid && state_reg.ready;
  assign stack_top_entry = state_reg.stack[state_reg.sp - 3'h1];
  assign lit_k = instr_word[7:0];
  assign rrf_wb = state_reg.rrf_pend && (state_reg.hold == crrs_pkg::CYCLE_CLKS - 4'h1);
  assign rot_res = {state_reg.c, a_rdata[7:1]};
  assign diff9 = {1'b0, lit_k} - {1'b0, state_reg.w};
  assign diff5 = {1'b0, lit_k[3:0]} - {1'b0, state_reg.w[3:0]};
  assign b_we = (state_reg.bst == crrs_pkg::BUS_ACK) && avs_write && avs_byteenable[0]
                && (avs_address == crrs_pkg::ADR_FDATA);

  // ****************************************************************
  // File register memory
  // ****************************************************************
  crrs_fmem #(.AW(7), .DW(8)) u_fmem (
    .clk(clk),
    .a_addr(state_reg.fa),
    .a_we(rrf_wb && state_reg.fd),
    .a_wdata(rot_res),
    .a_rdata(a_rdata),
    .b_addr(state_reg.faddr),
    .b_we(b_we),
    .b_wdata(avs_writedata[7:0]),
    .b_rdata(b_rdata)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    // Free-running watchdog with prescaler
    state_next.pre = state_reg.pre + 8'h01;
    if (state_reg.pre == 8'hff) begin
      state_next.wdt = state_reg.wdt + 8'h01;
    end
    // Avalon slave, one answer per request
    case (state_reg.bst)
      crrs_pkg::BUS_IDLE: begin
        if (avs_read && avs_address == crrs_pkg::ADR_FDATA) begin
          state_next.bst = crrs_pkg::BUS_RD;
        end else if (avs_read || avs_write) begin
          state_next.bst = crrs_pkg::BUS_ACK;
          state_next.wait_r = 1'b0;
          case (avs_address)
            crrs_pkg::ADR_ACCUM: state_next.rdata = {24'h000000, state_reg.w};
            crrs_pkg::ADR_STATUS: state_next.rdata = {27'h0000000, state_reg.to,
              state_reg.pd, state_reg.z, state_reg.dc, state_reg.c};
            crrs_pkg::ADR_PC: state_next.rdata = {19'h00000, state_reg.pc};
            crrs_pkg::ADR_STACK: state_next.rdata = {29'h00000000, state_reg.sp};
            crrs_pkg::ADR_WDOG: state_next.rdata = {16'h0000, state_reg.pre, state_reg.wdt};
            crrs_pkg::ADR_CTRL: state_next.rdata =
              {31'h00000000, state_reg.st == crrs_pkg::CORE_SLEEP};
            crrs_pkg::ADR_FADDR: state_next.rdata = {25'h0000000, state_reg.faddr};
            default: state_next.rdata = 32'h00000000;
          endcase
        end
      end
      crrs_pkg::BUS_RD: begin
        state_next.rdata = {24'h000000, b_rdata};
        state_next.wait_r = 1'b0;
        state_next.bst = crrs_pkg::BUS_ACK;
      end
      crrs_pkg::BUS_ACK: begin
        state_next.wait_r = 1'b1;
        state_next.bst = crrs_pkg::BUS_IDLE;
        if (avs_write && avs_byteenable[0]) begin
          case (avs_address)
            crrs_pkg::ADR_ACCUM: state_next.w = avs_writedata[7:0];
            crrs_pkg::ADR_STATUS: begin
              state_next.c = avs_writedata[crrs_pkg::ST_C_POS];
              state_next.dc = avs_writedata[crrs_pkg::ST_DC_POS];
              state_next.z = avs_writedata[crrs_pkg::ST_Z_POS];
              state_next.pd = avs_writedata[crrs_pkg::ST_PD_POS];
              state_next.to = avs_writedata[crrs_pkg::ST_TO_POS];
            end
            crrs_pkg::ADR_STACK: begin
              state_next.stack[state_reg.sp] = avs_writedata[12:0];
              state_next.sp = state_reg.sp + 3'h1;
            end
            crrs_pkg::ADR_CTRL: begin
              if (avs_writedata[crrs_pkg::CTRL_WAKE_POS]
                  && state_reg.st == crrs_pkg::CORE_SLEEP) begin
                state_next.st = crrs_pkg::CORE_IDLE;
                state_next.ready = 1'b1;
                state_next.osc = 1'b1;
              end
            end
            crrs_pkg::ADR_FADDR: state_next.faddr = avs_writedata[6:0];
            default: state_next.faddr = state_reg.faddr;
          endcase
        end
      end
      default: state_next.bst = crrs_pkg::BUS_IDLE;
    endcase
    // Instruction execution, wins over any bus write
    case (state_reg.st)
      crrs_pkg::CORE_IDLE: begin
        if (take) begin
          state_next.ready = 1'b0;
          state_next.st = crrs_pkg::CORE_BUSY;
          state_next.pc = state_reg.pc + 13'h0001;
          state_next.hold = crrs_pkg::CYCLE_CLKS;
          if (instr_word == crrs_pkg::OP_RETURN) begin
            state_next.pc = stack_top_entry;
            state_next.sp = state_reg.sp - 3'h1;
            state_next.hold = 4'(crrs_pkg::CYCLE_CLKS * crrs_pkg::CYCLES_RETURN);
          end else if (instr_word[13:8] == crrs_pkg::OP_RRF_HI) begin
            state_next.fa = instr_word[6:0];
            state_next.fd = instr_word[crrs_pkg::DEST_BIT];
            state_next.rrf_pend = 1'b1;
          end else if (instr_word == crrs_pkg::OP_SLEEP) begin
            state_next.pd = 1'b0;
            state_next.to = 1'b1;
            state_next.wdt = 8'h00;
            state_next.pre = 8'h00;
            state_next.slp = 1'b1;
          end else if (instr_word[13:9] == crrs_pkg::OP_SUB_HI) begin
            state_next.w = diff9[7:0];
            state_next.c = ~diff9[8];
            state_next.dc = ~diff5[4];
            state_next.z = (diff9[7:0] == 8'h00);
          end
        end
      end
      crrs_pkg::CORE_BUSY: begin
        state_next.hold = state_reg.hold - 4'h1;
        // Rotate result lands one clock after the read data arrive
        if (rrf_wb) begin
          state_next.rrf_pend = 1'b0;
          state_next.c = a_rdata[0];
          if (!state_reg.fd) begin
            state_next.w = rot_res;
          end
        end
        // Last clock of the cycle: halt after sleep, otherwise take the next word
        if (state_reg.hold == 4'h1) begin
          if (state_reg.slp) begin
            state_next.st = crrs_pkg::CORE_SLEEP;
            state_next.osc = 1'b0;
            state_next.slp = 1'b0;
          end else begin
            state_next.st = crrs_pkg::CORE_IDLE;
            state_next.ready = 1'b1;
          end
        end
      end
      crrs_pkg::CORE_SLEEP: begin
        // Stay halted unless a wake write has just landed
        if (state_next.st == crrs_pkg::CORE_SLEEP) begin
          state_next.osc = 1'b0;
        end
      end
      default: state_next.st = crrs_pkg::CORE_IDLE;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.st <= crrs_pkg::CORE_IDLE;
      state_reg.bst <= crrs_pkg::BUS_IDLE;
      state_reg.ready <= 1'b1;
      state_reg.osc <= 1'b1;
      state_reg.wait_r <= 1'b1;
      state_reg.pc <= crrs_pkg::RST_PC;
      state_reg.w <= crrs_pkg::RST_ACCUM;
      state_reg.pd <= crrs_pkg::RST_PD;
      state_reg.to <= crrs_pkg::RST_TO;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign instr_ready = state_reg.ready;
  assign prog_addr = state_reg.pc;
  assign osc_run = state_reg.osc;
  assign avs_readdata = state_reg.rdata;
  assign avs_waitrequest = state_reg.wait_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] k_past;
  logic take_ret;
  logic take_rrf;
  logic take_slp;
  logic take_sub;
  assign take_ret = take && instr_word == crrs_pkg::OP_RETURN;
  assign take_rrf = take && instr_word[13:8] == crrs_pkg::OP_RRF_HI;
  assign take_slp = take && instr_word == crrs_pkg::OP_SLEEP;
  assign take_sub = take && instr_word[13:9] == crrs_pkg::OP_SUB_HI;
  assign k_past = lit_k;

  sequence seq_one_cycle;
    !instr_ready [*4] ##1 instr_ready;
  endsequence
  sequence seq_two_cycles;
    !instr_ready [*8] ##1 instr_ready;
  endsequence

  AST_RET_PC: assert property (take_ret |=> prog_addr == $past(stack_top_entry))
    else $error("return did not load the stack top");
  AST_RET_FLAGS: assert property (take_ret && state_reg.bst != crrs_pkg::BUS_ACK
    |=> $stable(state_reg.c) && $stable(state_reg.z) && $stable(state_reg.dc))
    else $error("return changed a flag");
  AST_RET_LEN: assert property (take_ret |=> seq_two_cycles)
    else $error("return length wrong");
  AST_RRF_ACC: assert property (rrf_wb && !state_reg.fd
    |=> state_reg.w == {$past(state_reg.c), $past(a_rdata[7:1])})
    else $error("rotate result not in accumulator");
  AST_RRF_FILE: assert property (
    rrf_wb && state_reg.fd && state_reg.bst != crrs_pkg::BUS_ACK
    |=> u_fmem.mem[$past(state_reg.fa)] == {$past(state_reg.c), $past(a_rdata[7:1])}
    && $stable(state_reg.w))
    else $error("rotate to file touched accumulator");
  AST_RRF_CARRY: assert property (rrf_wb |=> state_reg.c == $past(a_rdata[0]))
    else $error("rotate carry wrong");
  AST_RRF_LEN: assert property (take_rrf |=> seq_one_cycle)
    else $error("rotate length wrong");
  AST_SLP_PD: assert property (take_slp |=> !state_reg.pd)
    else $error("sleep left power-down set");
  AST_SLP_TO: assert property (take_slp |=> state_reg.to)
    else $error("sleep left timeout clear");
  AST_SLP_WDT: assert property (take_slp |=> state_reg.wdt == 8'h00
    && state_reg.pre == 8'h00)
    else $error("sleep did not clear watchdog");
  AST_SLP_OSC: assert property (take_slp |=> osc_run [*4] ##1 !osc_run [*2])
    else $error("oscillator not halted after sleep");
  AST_SUB_W: assert property (take_sub |=> state_reg.w == 8'($past(k_past)
    - $past(state_reg.w)))
    else $error("subtract result wrong");
  AST_SUB_C: assert property (take_sub
    |=> state_reg.c == ($past(k_past) >= $past(state_reg.w)))
    else $error("subtract carry wrong");
  AST_SUB_Z: assert property (take_sub |=> state_reg.z == (state_reg.w == 8'h00))
    else $error("subtract zero flag wrong");
  AST_SUB_DC: assert property (take_sub
    |=> state_reg.dc == ($past(k_past[3:0]) >= $past(state_reg.w[3:0])))
    else $error("subtract digit carry wrong");

endmodule // crrs_core

// ==== testbench/crrs_pmem.sv ====
// Program memory model that offers one instruction word per request
`timescale 1ns/100ps
module crrs_pmem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_ready,
  input wire logic go,
  input wire logic [3:0] lag,
  input wire logic [13:0] word_in,
  output logic instr_valid,
  output logic [13:0] instr_word,
  output logic taken
);
  // ****************************************************************
  // Offer and hand-over
  // ****************************************************************
  logic [3:0] wait_reg;

  // Offer after lag cycles, hold until taken, then scramble the word lines
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      instr_valid <= 1'b0;
      instr_word <= 14'h0000;
      taken <= 1'b0;
      wait_reg <= 4'h0;
    end else begin
      taken <= 1'b0;
      if (instr_valid && instr_ready) begin
        instr_valid <= 1'b0;
        instr_word <= ~instr_word; // Released lines stop showing the word
        taken <= 1'b1;
      end else if (go && !instr_valid && !taken) begin
        if (wait_reg == lag) begin
          instr_valid <= 1'b1;
          instr_word <= word_in;
          wait_reg <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule // crrs_pmem

// ==== testbench/tb_cpu_return_rotate_sleep_literal_minus_accum_op.sv ====
// Self-checking bench for the four-instruction executor
`timescale 1ns/100ps
module tb_cpu_return_rotate_sleep_literal_minus_accum_op;
  // ****************************************************************
  // Signals and case table
  // ****************************************************************
  typedef struct packed {
    logic [7:0] w;
    logic [4:0] st;
    logic [7:0] f;
    logic [13:0] op;
    logic [7:0] ew;
    logic [4:0] est;
    logic [7:0] ef;
  } crrs_row_t;
  logic clk, rst_n, go, taken, instr_valid, instr_ready, osc_run;
  logic avs_read, avs_write, avs_waitrequest;
  logic [13:0] word_in, instr_word;
  logic [12:0] prog_addr, pc_e;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable, lag;
  int mismatches, compares;
  // Accumulator, status, file value, opcode, then expected results
  crrs_row_t rows [8] = '{
    '{8'h01, 5'h18, 8'h00, 14'h3c02, 8'h01, 5'h1b, 8'h00},
    '{8'h02, 5'h18, 8'h00, 14'h3c02, 8'h00, 5'h1f, 8'h00},
    '{8'h03, 5'h18, 8'h00, 14'h3d02, 8'hff, 5'h18, 8'h00},
    '{8'h01, 5'h18, 8'h00, 14'h3c10, 8'h0f, 5'h19, 8'h00},
    '{8'h00, 5'h18, 8'h00, 14'h3cff, 8'hff, 5'h1b, 8'h00},
    '{8'h55, 5'h18, 8'he6, 14'h0c25, 8'h73, 5'h18, 8'he6},
    '{8'h55, 5'h1a, 8'h01, 14'h0ca5, 8'h55, 5'h1b, 8'h00},
    '{8'h55, 5'h1f, 8'he6, 14'h0c25, 8'hf3, 5'h1e, 8'he6}};

  crrs_pmem pm (.clk(clk), .rst_n(rst_n), .instr_ready(instr_ready), .go(go), .lag(lag),
    .word_in(word_in), .instr_valid(instr_valid), .instr_word(instr_word), .taken(taken));
  crrs_core dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .prog_addr(prog_addr), .osc_run(osc_run),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts and verdict
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    avs_address <= a;
    avs_write <= wr_en;
    avs_read <= !wr_en;
    avs_writedata <= d;
    avs_byteenable <= be;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      mismatches++;
      finish_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  // Issue one word; n is the expected busy length, 0 for sleep
  task automatic exec(input logic [13:0] op, input int n);
    int k;
    go <= 1'b1;
    word_in <= op;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (taken !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
      finish_test();
    end
    go <= 1'b0;
    if (n > 0) begin
      k = 0;
      while (instr_ready === 1'b0 && k < 20) begin
        k++;
        @(posedge clk);
      end
      check(32'(k), 32'(n), "busy clocks");
    end else begin
      check({31'h0, osc_run}, 32'h1, "oscillator just after sleep");
      repeat (4) @(posedge clk);
      check({31'h0, osc_run}, 32'h0, "oscillator in sleep");
      check({31'h0, instr_ready}, 32'h0, "ready in sleep");
    end
  endtask

  // ****************************************************************
  // Clock, timeout and main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  // Reset, table walk, then hand-written cases
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    word_in = 14'h0;
    lag = 4'h0;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    mismatches = 0;
    compares = 0;
    pc_e = 13'h0;
    repeat (8) @(posedge clk);
    check({avs_waitrequest, instr_ready, osc_run, 16'h0, prog_addr}, 32'he0000000, "reset pins");
    rst_n <= 1'b1;
    @(posedge clk);
    rd(crrs_pkg::ADR_STATUS);
    check(q, 32'h18, "status after reset");
    bus(1'b1, crrs_pkg::ADR_ACCUM, 32'haa, 4'he);
    rd(crrs_pkg::ADR_ACCUM);
    check(q, 32'h0, "accumulator after masked write");
    rd(5'h03);
    check(q, 32'h0, "unmapped read");
    for (int i = 0; i < 8; i++) begin
      lag <= 4'(i % 3);
      wr(crrs_pkg::ADR_ACCUM, {24'h0, rows[i].w});
      wr(crrs_pkg::ADR_STATUS, {27'h0, rows[i].st});
      wr(crrs_pkg::ADR_FADDR, 32'h25);
      wr(crrs_pkg::ADR_FDATA, {24'h0, rows[i].f});
      exec(rows[i].op, 4);
      pc_e = pc_e + 13'h1;
      rd(crrs_pkg::ADR_ACCUM);
      check(q, {24'h0, rows[i].ew}, "accumulator");
      rd(crrs_pkg::ADR_STATUS);
      check(q, {27'h0, rows[i].est}, "status");
      rd(crrs_pkg::ADR_FDATA);
      check(q, {24'h0, rows[i].ef}, "file register");
      check({19'h0, prog_addr}, {19'h0, pc_e}, "program counter");
    end
    rd(crrs_pkg::ADR_FADDR);
    check(q, 32'h25, "file address register");
    // Return keeps every flag and pops the pushed entry
    wr(crrs_pkg::ADR_STATUS, 32'h1f);
    wr(crrs_pkg::ADR_STACK, 32'h0abc);
    rd(crrs_pkg::ADR_STACK);
    check(q, 32'h1, "stack depth after push");
    exec(crrs_pkg::OP_RETURN, 8);
    check({19'h0, prog_addr}, 32'h0abc, "return target");
    rd(crrs_pkg::ADR_STATUS);
    check(q, 32'h1f, "status after return");
    rd(crrs_pkg::ADR_STACK);
    check(q, 32'h0, "stack depth after pop");
    rd(crrs_pkg::ADR_PC);
    check(q, 32'h0abc, "program counter register");
    // Let the watchdog advance, then sleep
    repeat (600) @(posedge clk);
    wr(crrs_pkg::ADR_STATUS, 32'h0f);
    exec(crrs_pkg::OP_SLEEP, 0);
    rd(crrs_pkg::ADR_STATUS);
    check(q, 32'h17, "status after sleep");
    rd(crrs_pkg::ADR_WDOG);
    check({24'h0, q[7:0]}, 32'h0, "watchdog count");
    check({31'h0, q[15:8] < 8'h20}, 32'h1, "watchdog prescaler restarted");
    rd(crrs_pkg::ADR_CTRL);
    check({31'h0, q[0]}, 32'h1, "sleeping");
    wr(crrs_pkg::ADR_CTRL, 32'h1);
    for (int k = 0; k < 20 && instr_ready !== 1'b1; k++) begin
      @(posedge clk);
    end
    check({30'h0, instr_ready, osc_run}, 32'h3, "awake");
    check({19'h0, prog_addr}, 32'h0abd, "counter after sleep");
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({avs_waitrequest, instr_ready, osc_run, 16'h0, prog_addr}, 32'he0000000, "pins again");
    rd(crrs_pkg::ADR_STATUS);
    check(q, 32'h18, "status after second reset");
    finish_test();
  end
endmodule // tb_cpu_return_rotate_sleep_literal_minus_accum_op
